// ==== rtl/sar_conversion_sequencer.sv ====
// Successive-approximation conversion sequencer (device end)
//
// Contract
// (R1) Trigger sets busy flag
// (R2) Busy releases gated clock, 17 cycles full
// (R3) Trigger trailing edge initialises register, busy, clock
// (R4) First step trials MSB; later steps decide, trial next
// (R5) After LSB decision busy clears, result valid
// (R6) Busy clear holds clock low until next
// (R7) Parallel bit valid on its decision edge
// (R8) Result pins negative true
// (R9) Complementary straight or offset binary coding
// (R10) Parallel valid 20 ns before busy falls
// (R11) Serial NRZ, one bit per clock, MSB first
// (R12) Outputs change only on clock rising edges
// (R13) Host shifts serial on falling edges
// (R14) Host sees 17 falling edges, first invalid
// (R15) All serial bits placed at conversion end
// (R16) Early stop after bit n decision
// (R17) Early stop at 8,10,12,13,14,15; else 16
// (R18) Clock 1.6 MHz fast or 933 kHz slow
// (R19) External pulse pacing, done after 17 pulses
// (R20) Keep bit per comparator at trial end
// (R21) Comparator input sampled once per step
`timescale 1ns/1ps
module sar_conversion_sequencer
	import sar_seq_pkg::*;
#(
	parameter bit SLOW_VARIANT = 1'b0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic comparator,
	input wire logic [4:0] short_cycle_bits,
	input wire logic ext_clock_mode,
	sar_link_if.device link
);
	localparam int HALF_RAW = SLOW_VARIANT ? SLOW_HALF_CYC : FAST_HALF_CYC; // [R18]
	// High phase must also cover the data lead before busy falls
	localparam int HALF_CYC = (HALF_RAW > VALID_LEAD_CYC) ? HALF_RAW : VALID_LEAD_CYC; // [R10]
	localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(HALF_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	logic trig_s1;
	logic trig_s2;
	logic trig_d;
	logic cmp_s1;
	logic cmp_s2;
	logic trig_rise;
	logic trig_fall;

	always_ff @(posedge mclk) begin
		if (rst) begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_d <= 1'b0;
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
		end else begin
			trig_s1 <= link.convert_start;
			trig_s2 <= trig_s1;
			trig_d <= trig_s2;
			cmp_s1 <= comparator;
			cmp_s2 <= cmp_s1;
		end
	end

	assign trig_rise = trig_s2 & ~trig_d;
	assign trig_fall = ~trig_s2 & trig_d;

	////////////////////////////////////////////////////////////////////////////////
	// Open or unsupported selections fall back to full resolution
	function automatic logic [4:0] stop_step(input logic [4:0] sel);
		unique case (sel)
			5'h08, 5'h0a, 5'h0c, 5'h0d, 5'h0e, 5'h0f: stop_step = sel; // [R16] [R17]
			default: stop_step = FULL_BITS; // [R17]
		endcase
	endfunction

	seq_state_t state;
	seq_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [4:0] step;
	logic [4:0] next_step;
	logic [4:0] res;
	logic [4:0] next_res;
	logic last;
	logic next_last;
	logic [WORD_W-1:0] approximation_register;
	logic [WORD_W-1:0] next_approximation_register;
	logic busy;
	logic next_busy;
	logic clk_out;
	logic next_clk_out;
	logic ser;
	logic next_ser;
	logic [WORD_W-1:0] par;
	logic [WORD_W-1:0] next_par;
	logic step_now;
	logic [3:0] dec_idx;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_step = step;
		next_res = res;
		next_last = last;
		next_approximation_register = approximation_register;
		next_busy = busy;
		next_clk_out = clk_out;
		next_ser = ser;
		next_par = par;
		step_now = 1'b0;
		dec_idx = 4'(WORD_W - int'(step));
		// With the internal clock, the leading edge of the trigger marks a conversion in progress
		if (trig_rise && state == SEQ_IDLE && !ext_clock_mode) begin
			next_busy = 1'b1; // [R1]
		end
		if (trig_fall && (state == SEQ_IDLE || !ext_clock_mode)) begin
			// With the internal clock, a trailing edge mid-conversion restarts from scratch
			next_state = SEQ_RUN; // [R3]
			next_busy = 1'b1; // [R1] [R2]
			next_approximation_register = TRIAL_MSB; // [R4]
			next_par = ~TRIAL_MSB; // [R8] [R9]
			next_clk_out = 1'b1; // [R12]
			next_cnt = HALF_LOAD;
			next_step = STEP_W1;
			next_res = stop_step(short_cycle_bits);
			next_last = 1'b0;
		end else if (state == SEQ_RUN) begin
			if (ext_clock_mode) begin
				// Each external pulse whose trailing edge finds the clock low replaces one internal clock pulse
				step_now = trig_fall && !clk_out && !last; // [R19]
			end else begin
				step_now = (cnt == '0) && !clk_out && !last; // [R2]
			end
			if (cnt != '0) begin
				next_cnt = cnt - CNT_W'(1);
			end else if (clk_out) begin
				next_clk_out = 1'b0;
				if (last) begin
					// Falls a full high phase after the last decision
					next_state = SEQ_IDLE; // [R5] [R16]
					next_busy = 1'b0; // [R5] [R10]
				end else begin
					next_cnt = HALF_LOAD;
				end
			end
			if (step_now) begin
				next_approximation_register[dec_idx] = cmp_s2; // [R20] [R21]
				if (step < res) begin
					next_approximation_register[dec_idx - 4'h1] = 1'b1; // [R4]
				end
				next_last = (step == res); // [R5] [R16]
				next_par = ~next_approximation_register; // [R7] [R8]
				next_ser = ~cmp_s2; // [R11] [R8]
				next_clk_out = 1'b1; // [R12]
				next_cnt = HALF_LOAD;
				next_step = step + STEP_W1;
			end
		end
		if (state == SEQ_IDLE && !next_busy) begin
			next_clk_out = 1'b0; // [R6]
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= SEQ_IDLE;
			cnt <= '0;
			step <= '0;
			res <= FULL_BITS;
			last <= 1'b0;
			approximation_register <= '0;
			busy <= 1'b0;
			clk_out <= 1'b0;
			ser <= 1'b1;
			par <= '1;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			step <= next_step;
			res <= next_res;
			last <= next_last;
			approximation_register <= next_approximation_register;
			busy <= next_busy;
			clk_out <= next_clk_out;
			ser <= next_ser;
			par <= next_par;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign link.conv_clk = clk_out;
	assign link.busy = busy;
	assign link.serial_n = ser;
	assign link.parallel_n = par;
endmodule // sar_conversion_sequencer

// ==== rtl/sar_link_if.sv ====
// Pins between the converter sequencer and the host receiver
`timescale 1ns/1ps
interface sar_link_if;
	logic convert_start;
	logic conv_clk;
	logic busy;
	logic serial_n;
	logic [15:0] parallel_n;
	modport device (input convert_start, output conv_clk, output busy, output serial_n, output parallel_n);
	modport host (output convert_start, input conv_clk, input busy, input serial_n, input parallel_n);
endinterface

// ==== rtl/sar_result_receiver.sv ====
// Host end: issues the trigger and captures parallel and serial results
`timescale 1ns/1ps
module sar_result_receiver
	import sar_seq_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic ext_pacing,
	output logic start_ready,
	output logic out_valid,
	input wire logic out_ready,
	output logic [15:0] out_parallel,
	output logic [15:0] out_serial,
	sar_link_if.host link
);
	localparam logic [CNT_W-1:0] START_LOAD = CNT_W'(START_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	logic [1:0] clk_s;
	logic [1:0] busy_s;
	logic [1:0] ser_s;
	logic [WORD_W-1:0] par_s1;
	logic [WORD_W-1:0] par_s2;
	logic clk_d;
	logic busy_d;
	logic clk_fall;
	logic busy_fall;

	always_ff @(posedge mclk) begin
		if (rst) begin
			clk_s <= '0;
			busy_s <= '0;
			ser_s <= '1;
			par_s1 <= '1;
			par_s2 <= '1;
			clk_d <= 1'b0;
			busy_d <= 1'b0;
		end else begin
			clk_s <= {clk_s[0], link.conv_clk};
			busy_s <= {busy_s[0], link.busy};
			ser_s <= {ser_s[0], link.serial_n};
			par_s1 <= link.parallel_n;
			par_s2 <= par_s1;
			clk_d <= clk_s[1];
			busy_d <= busy_s[1];
		end
	end

	assign clk_fall = clk_d & ~clk_s[1];
	assign busy_fall = busy_d & ~busy_s[1];

	////////////////////////////////////////////////////////////////////////////////
	rx_state_t state;
	rx_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic trig;
	logic next_trig;
	logic [WORD_W-1:0] shreg;
	logic [WORD_W-1:0] next_shreg;
	logic tail_valid;
	logic next_tail_valid;
	logic [2*WORD_W-1:0] tail;
	logic [2*WORD_W-1:0] next_tail;
	logic next_out_valid;
	logic [2*WORD_W-1:0] next_head;
	logic next_start_ready;
	logic push;
	logic pop;
	logic [2*WORD_W-1:0] word;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_trig = trig;
		next_shreg = shreg;
		next_tail_valid = tail_valid;
		next_tail = tail;
		next_out_valid = out_valid;
		next_head = {out_parallel, out_serial};
		// First fall brings an invalid bit that the 17th fall pushes out at full resolution; short cycles leave it in [R14] [R13]
		if (clk_fall) begin
			next_shreg = {shreg[WORD_W-2:0], ~ser_s[1]};
		end
		// Busy fall: parallel word already settled, serial word complete [R10] [R15]
		push = busy_fall;
		word = {~par_s2, next_shreg};
		pop = out_valid && out_ready;
		if (pop) begin
			next_out_valid = tail_valid || push;
			next_head = tail_valid ? tail : word;
			next_tail_valid = tail_valid && push;
			next_tail = word;
		end else if (push) begin
			if (!out_valid) begin
				next_out_valid = 1'b1;
				next_head = word;
			end else begin
				next_tail_valid = 1'b1;
				next_tail = word;
			end
		end
		unique case (state)
			RX_IDLE: begin
				if (start && start_ready) begin
					next_state = RX_PULSE;
					next_trig = 1'b1;
					next_cnt = START_LOAD;
				end
			end
			RX_PULSE: begin
				if (cnt != '0) begin
					next_cnt = cnt - CNT_W'(1);
				end else begin
					next_trig = 1'b0;
					// Paced pulses do not wait for a result
					next_state = ext_pacing ? RX_IDLE : RX_WAIT; // [R19]
				end
			end
			RX_WAIT: begin
				if (busy_fall) begin
					next_state = RX_IDLE;
				end
			end
			default: begin
				next_state = RX_IDLE;
				next_trig = 1'b0;
			end
		endcase
		// A start is only taken when a result can be held, so no word is lost
		next_start_ready = (next_state == RX_IDLE) && !next_tail_valid;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= RX_IDLE;
			cnt <= '0;
			trig <= 1'b0;
			shreg <= '0;
			tail_valid <= 1'b0;
			tail <= '0;
			out_valid <= 1'b0;
			out_parallel <= '0;
			out_serial <= '0;
			start_ready <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			trig <= next_trig;
			shreg <= next_shreg;
			tail_valid <= next_tail_valid;
			tail <= next_tail;
			out_valid <= next_out_valid;
			{out_parallel, out_serial} <= next_head;
			start_ready <= next_start_ready;
		end
	end

	assign link.convert_start = trig;
endmodule // sar_result_receiver

// ==== rtl/sar_seq_pkg.sv ====
// Shared constants for the conversion sequencer and its result receiver
package sar_seq_pkg;
	localparam int WORD_W = 16;
	localparam int MCLK_KHZ = 250000;
	localparam int MCLK_PERIOD_NS = 4;
	// Conversion clock, fast and slow variant
	localparam int FAST_CLK_KHZ = 1600;
	localparam int SLOW_CLK_KHZ = 933;
	localparam int FAST_HALF_CYC = MCLK_KHZ / (2 * FAST_CLK_KHZ);
	localparam int SLOW_HALF_CYC = MCLK_KHZ / (2 * SLOW_CLK_KHZ);
	localparam int CNT_W = 8;
	// Parallel data leads the busy fall by at least this much
	localparam int VALID_LEAD_NS = 20;
	localparam int VALID_LEAD_CYC = (VALID_LEAD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	// Trigger pulse made by the host, legal width 100 to 700 ns
	localparam int START_NS = 200;
	localparam int START_CYC = (START_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam logic [4:0] FULL_BITS = 5'h10;
	localparam logic [4:0] STEP_W1 = 5'h01;
	localparam logic [WORD_W-1:0] TRIAL_MSB = 16'h8000;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_RUN = 2'b10
	} seq_state_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_PULSE = 3'b010,
		RX_WAIT = 3'b100
	} rx_state_t;
endpackage

// ==== verification/sar_link_asserts.sv ====
// Concurrent checks on the link between sequencer and receiver
`timescale 1ns/1ps
module sar_link_asserts
	import sar_seq_pkg::*;
#(
	parameter bit SLOW_VARIANT = 1'b0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic convert_start,
	input wire logic conv_clk,
	input wire logic busy,
	input wire logic serial_n,
	input wire logic [15:0] parallel_n,
	input wire logic ext_mode
);
	localparam int HALF = SLOW_VARIANT ? SLOW_HALF_CYC : FAST_HALF_CYC;
	logic [CNT_W-1:0] high_run;
	logic [CNT_W-1:0] next_high_run;
	logic [4:0] rises;
	logic [4:0] next_rises;
	logic clk_d;
	// Edge tally runs only while busy, so paced trigger pulses do not clear it mid-conversion
	always_comb begin
		next_high_run = conv_clk ? high_run + 8'h01 : 8'h00;
		next_rises = busy ? rises + {4'h0, conv_clk & ~clk_d} : 5'h00;
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			high_run <= 8'h00;
			rises <= 5'h00;
			clk_d <= 1'b0;
		end else begin
			high_run <= next_high_run;
			rises <= next_rises;
			clk_d <= conv_clk;
		end
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_busy_on_start: assert property ((!ext_mode && $rose(convert_start)) |-> ##[1:8] busy)
		else $error("busy not raised after trigger");
	a_idle_clk_low: assert property (!busy |-> !conv_clk)
		else $error("clock running while idle");
	a_first_trial: assert property (($fell(convert_start) && (!ext_mode || !busy)) |->
		##[1:6] ($rose(conv_clk) && parallel_n == 16'h7fff))
		else $error("first trial pattern missing");
	a_ext_step: assert property ((ext_mode && busy && !conv_clk && $fell(convert_start)) |-> ##[1:6] $rose(conv_clk))
		else $error("paced pulse did not step the conversion");
	a_out_on_rise: assert property ((parallel_n != $past(parallel_n) || serial_n != $past(serial_n)) |-> $rose(conv_clk))
		else $error("result changed off a clock rise");
	a_lead_busy_fall: assert property ($fell(busy) |-> parallel_n == $past(parallel_n, 5))
		else $error("parallel word not settled before busy fall");
	a_high_half: assert property ($fell(conv_clk) |-> high_run == HALF)
		else $error("clock high phase length wrong");
	a_serial_step: assert property (($rose(conv_clk) && rises != 5'h00) |-> serial_n == parallel_n[5'h10 - rises])
		else $error("serial bit does not match decided bit");
	a_rise_count: assert property ($fell(busy) |-> rises inside {5'h09, 5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11})
		else $error("clock rise count wrong at busy fall");
endmodule // sar_link_asserts

// ==== verification/tb_top.sv ====
// Bench joining the sequencer and the receiver over the link
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic mclk;
	logic rst;
	logic comparator;
	logic ext_clock_mode;
	logic start;
	logic ext_pacing;
	logic out_ready;
	logic [4:0] short_cycle_bits;
	logic [15:0] target;
	logic start_ready;
	logic out_valid;
	logic [15:0] out_parallel;
	logic [15:0] out_serial;
	logic [4:0] res_tab [8] = '{5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h0a, 5'h08, 5'h00};
	logic [15:0] tgt_tab [8] = '{16'h677a, 16'hffff, 16'h0000, 16'h8001, 16'h5a5a, 16'hc3c3, 16'h00ff, 16'ha5a5};
	int error_cnt = 0;
	int cmp_count = 0;
	sar_link_if link();
	sar_conversion_sequencer #(.SLOW_VARIANT(1'b0)) i_sar_conversion_sequencer (.mclk(mclk), .rst(rst),
		.comparator(comparator), .short_cycle_bits(short_cycle_bits), .ext_clock_mode(ext_clock_mode), .link(link.device));
	sar_result_receiver i_sar_result_receiver (.mclk(mclk), .rst(rst), .start(start), .ext_pacing(ext_pacing),
		.start_ready(start_ready), .out_valid(out_valid), .out_ready(out_ready), .out_parallel(out_parallel),
		.out_serial(out_serial), .link(link.host));
	sar_link_asserts #(.SLOW_VARIANT(1'b0)) i_sar_link_asserts (.mclk(mclk), .rst(rst),
		.convert_start(link.convert_start), .conv_clk(link.conv_clk), .busy(link.busy), .serial_n(link.serial_n),
		.parallel_n(link.parallel_n), .ext_mode(ext_clock_mode));
	// Ideal analog input: a trial is kept while it does not exceed the target
	always @(negedge mclk) comparator <= (target >= ~link.parallel_n);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic do_conv(input logic [4:0] res, input logic [15:0] tgt, output logic [15:0] exp);
		int i;
		int n;
		int r;
		bit seen;
		bit prev;
		r = (res inside {5'h08, 5'h0a, 5'h0c, 5'h0d, 5'h0e, 5'h0f}) ? int'(res) : 16;
		exp = tgt & (16'hffff << (16 - r));
		short_cycle_bits = res;
		target = tgt;
		kick();
		n = 0;
		seen = 0;
		prev = 0;
		for (i = 0; i < 4000 && !(seen && link.busy === 1'b0); i++) begin
			@(negedge mclk);
			n += (link.conv_clk === 1'b1 && !prev);
			prev = link.conv_clk === 1'b1;
			seen |= link.busy === 1'b1;
		end
		`CHK(n, r + 1);
		`CHK(link.parallel_n, ~exp);
	endtask
	// Start stays up until the receiver takes it, then drops at the next falling edge
	task automatic kick;
		int i;
		bit ok;
		start = 1'b1;
		i = 0;
		do begin
			ok = start_ready === 1'b1;
			@(negedge mclk);
			i++;
		end while (!ok && i < 5000);
		start = 1'b0;
	endtask
	// Paced pulses spaced well past a clock high phase, since an early trailing edge is refused
	task automatic do_ext(input logic [15:0] tgt);
		int p;
		ext_clock_mode = 1'b1;
		ext_pacing = 1'b1;
		short_cycle_bits = 5'h10;
		target = tgt;
		for (p = 0; p < 17; p++) begin
			kick();
			repeat (200) @(negedge mclk);
		end
		`CHK(link.busy, 1'b0);
		`CHK(link.parallel_n, ~tgt);
		ext_clock_mode = 1'b0;
		ext_pacing = 1'b0;
	endtask
	// Reader stalls until called, so results pile up in the two-entry buffer
	task automatic take(input logic [15:0] exp, input bit full);
		int i;
		out_ready = 1'b1;
		i = 0;
		while (out_valid !== 1'b1 && i < 100) begin
			@(negedge mclk);
			i++;
		end
		`CHK(out_valid, 1'b1);
		`CHK(out_parallel, exp);
		if (full) `CHK(out_serial, exp);
		@(negedge mclk);
		out_ready = 1'b0;
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		error_cnt++;
		end_sim;
	end
	initial begin
		logic [15:0] e;
		logic [15:0] f;
		rst = 1'b1;
		ext_clock_mode = 1'b0;
		start = 1'b0;
		ext_pacing = 1'b0;
		out_ready = 1'b0;
		short_cycle_bits = 5'h10;
		target = 16'h0000;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		for (int k = 0; k < 8; k++) begin
			do_conv(res_tab[k], tgt_tab[k], e);
			take(e, res_tab[k] == 5'h10 || res_tab[k] == 5'h00);
		end
		do_ext(16'h3c5a);
		take(16'h3c5a, 1'b1);
		do_conv(5'h10, 16'h1111, e);
		do_conv(5'h10, 16'hfffe, f);
		repeat (10) @(negedge mclk);
		`CHK(start_ready, 1'b0);
		take(e, 1'b1);
		take(f, 1'b1);
		end_sim;
	end
endmodule // tb_top
